// file: common/p6b_pkg.sv
package p6b_pkg;
    localparam int          P6B_DATA_W   = 8;
    localparam int          P6B_ADR_W    = 22;
    // register indices; byte address is four times the index
    localparam logic [19:0] P6B_IDX_DDR  = 20'hEE005;
    localparam logic [19:0] P6B_IDX_DR   = 20'hFFFD5;
    localparam logic [19:0] P6B_IDX_CFG  = 20'hEE006;
    localparam logic [7:0]  P6B_DDR_RST  = 8'h80;
    localparam logic [7:0]  P6B_DR_RST   = 8'h80;
    localparam logic [7:0]  P6B_DDR_READ = 8'hFF;
    localparam logic [7:0]  P6B_FIX_MASK = 8'h80;
    localparam logic [2:0]  P6B_CFG_RST  = 3'h0;
    // configuration register fields
    localparam int          P6B_CFG_STOP = 0;
    localparam int          P6B_CFG_BRLE = 1;
    localparam int          P6B_CFG_WAIT = 2;
    localparam int          P6B_CFG_MODE = 3;
    // pin positions
    localparam int          P6B_PIN_CLK  = 7;
    localparam int          P6B_PIN_BACK = 2;
    localparam int          P6B_PIN_BUS_RELEASE_REQUEST = 1;
    localparam int          P6B_PIN_WAIT = 0;
    localparam int          P6B_SYNC_N   = 3;

    typedef enum logic [1:0] {
        P6B_SEL_DDR,
        P6B_SEL_DR,
        P6B_SEL_CFG,
        P6B_SEL_NONE
    } p6b_sel_t;
endpackage : p6b_pkg

// file: core/p6b_pin_sync.sv
`timescale 1ns/1ns
module p6b_pin_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_n_in,
    // raw and filtered levels
    input  wire logic [W-1:0] raw_in,
    output logic      [W-1:0] level_out
);
    import p6b_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    initial begin
        if (W < 1) begin
            $error("p6b_pin_sync: width must be at least one");
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
        end else begin
            meta_r <= raw_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    // a level counts once the second and third stage agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    level_out[i] <= 1'b0;
                end else if (s2_r[i] == s3_r[i]) begin
                    level_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule : p6b_pin_sync

// file: core/p6b_port.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
module p6b_port #(
    parameter int ADR_W = p6b_pkg::P6B_ADR_W
) (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    // wishbone slave
    input  wire logic             wb_cyc_in,
    input  wire logic             wb_stb_in,
    input  wire logic             wb_we_in,
    input  wire logic [ADR_W-1:0] wb_adr_in,
    input  wire logic [3:0]       wb_sel_in,
    input  wire logic [31:0]      wb_dat_in,
    output logic      [31:0]      wb_dat_out,
    output logic                  wb_ack_out,
    // system state
    input  wire logic             expanded_mode_in,
    input  wire logic             hw_standby_in,
    input  wire logic             sw_standby_in,
    // bus controller side
    input  wire logic             sys_clock_level_in,
    input  wire logic             low_byte_write_strobe_n_in,
    input  wire logic             high_byte_write_strobe_n_in,
    input  wire logic             read_strobe_n_in,
    input  wire logic             address_strobe_n_in,
    input  wire logic             bus_release_ack_n_in,
    output logic                  bus_release_request_n_out,
    output logic                  wait_request_n_out,
    output logic                  sw_standby_seen_out,
    // port pins
    input  wire logic [7:0]       pin_in,
    output logic      [7:0]       pin_out,
    output logic      [7:0]       pin_oe_out
);
    import p6b_pkg::*;

    logic [7:0] port_six_direction_ctl_r;
    logic [7:0] port_six_output_data_r;
    logic       clock_out_stop_r;
    logic       bus_release_enable_r;
    logic       wait_pin_enable_r;
    logic [7:0] pin_level;
    logic [7:0] pin_out_nxt;
    logic [7:0] pin_oe_nxt;
    logic [7:0] rd_data_nxt;
    logic       ack_nxt;
    logic       wr_en;
    p6b_sel_t   sel;

    initial begin
        if (ADR_W < P6B_ADR_W) begin
            $error("p6b_port: address too narrow for the register map");
        end
    end

    function automatic p6b_sel_t decode(input logic [ADR_W-1:0] adr);
        logic [19:0] idx;
        idx = adr[21:2];
        // anything set above the 22-bit map selects nothing
        if (ADR_W > 22 && (adr >> 22) != '0) begin
            decode = P6B_SEL_NONE;
        end else if (idx == P6B_IDX_DDR) begin
            decode = P6B_SEL_DDR;
        end else if (idx == P6B_IDX_DR) begin
            decode = P6B_SEL_DR;
        end else if (idx == P6B_IDX_CFG) begin
            decode = P6B_SEL_CFG;
        end else begin
            decode = P6B_SEL_NONE;
        end
    endfunction : decode

    // pin levels pass four flip-flops before use
    p6b_pin_sync #(
        .W (8)
    ) u_sync (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .raw_in    (pin_in),
        .level_out (pin_level)
    );

    assign sel     = decode(wb_adr_in);
    assign ack_nxt = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_en   = ack_nxt && wb_we_in && wb_sel_in[0];

    // direction register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_six_direction_ctl_r <= P6B_DDR_RST;
        end else if (hw_standby_in) begin
            port_six_direction_ctl_r <= P6B_DDR_RST;
        end else if (wr_en && sel == P6B_SEL_DDR) begin
            port_six_direction_ctl_r <= wb_dat_in[7:0] | P6B_FIX_MASK;
        end
    end

    // data register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_six_output_data_r <= P6B_DR_RST;
        end else if (hw_standby_in) begin
            port_six_output_data_r <= P6B_DR_RST;
        end else if (wr_en && sel == P6B_SEL_DR) begin
            port_six_output_data_r <= wb_dat_in[7:0] | P6B_FIX_MASK;
        end
    end

    // clock-out stop and bus function enables
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {wait_pin_enable_r, bus_release_enable_r, clock_out_stop_r} <= P6B_CFG_RST;
        end else if (hw_standby_in) begin
            {wait_pin_enable_r, bus_release_enable_r, clock_out_stop_r} <= P6B_CFG_RST;
        end else if (wr_en && sel == P6B_SEL_CFG) begin
            clock_out_stop_r     <= wb_dat_in[P6B_CFG_STOP];
            bus_release_enable_r <= wb_dat_in[P6B_CFG_BRLE];
            wait_pin_enable_r    <= wb_dat_in[P6B_CFG_WAIT];
        end
    end

    // pin function selection
    always_comb begin
        pin_out_nxt = port_six_output_data_r;
        pin_oe_nxt  = port_six_direction_ctl_r;
        pin_oe_nxt[P6B_PIN_CLK]  = !clock_out_stop_r;
        pin_out_nxt[P6B_PIN_CLK] = sys_clock_level_in;
        if (expanded_mode_in) begin
            pin_oe_nxt[6:3]  = 4'hF;
            pin_out_nxt[6:3] = {low_byte_write_strobe_n_in, high_byte_write_strobe_n_in,
                                read_strobe_n_in, address_strobe_n_in};
            if (bus_release_enable_r) begin
                pin_oe_nxt[P6B_PIN_BACK]  = 1'b1;
                pin_out_nxt[P6B_PIN_BACK] = bus_release_ack_n_in;
                pin_oe_nxt[P6B_PIN_BUS_RELEASE_REQUEST]  = 1'b0;
            end
            if (wait_pin_enable_r) begin
                pin_oe_nxt[P6B_PIN_WAIT] = 1'b0;
            end
        end
    end

    // pins keep their drive in software standby; only hardware standby resets them
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_out_reg_reset: begin
                pin_out    <= P6B_DR_RST;
                pin_oe_out <= 8'h00;
            end
        end else begin
            pin_out    <= pin_out_nxt;
            pin_oe_out <= pin_oe_nxt;
        end
    end

    // bus function inputs seen from the pins
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_release_request_n_out <= 1'b1;
            wait_request_n_out        <= 1'b1;
            sw_standby_seen_out       <= 1'b0;
        end else begin
            bus_release_request_n_out <= !(expanded_mode_in && bus_release_enable_r)
                                         || pin_level[P6B_PIN_BUS_RELEASE_REQUEST];
            wait_request_n_out        <= !(expanded_mode_in && wait_pin_enable_r)
                                         || pin_level[P6B_PIN_WAIT];
            sw_standby_seen_out       <= sw_standby_in;
        end
    end

    // read data
    always_comb begin
        rd_data_nxt = 8'h00;
        case (sel)
            P6B_SEL_DDR: begin
                rd_data_nxt = P6B_DDR_READ;
            end
            P6B_SEL_DR: begin
                for (int i = 0; i < 7; i++) begin
                    rd_data_nxt[i] = port_six_direction_ctl_r[i] ?
                                     port_six_output_data_r[i] : pin_level[i];
                end
                rd_data_nxt[7] = clock_out_stop_r ? pin_level[7] : 1'b1;
            end
            P6B_SEL_CFG: begin
                rd_data_nxt[P6B_CFG_STOP] = clock_out_stop_r;
                rd_data_nxt[P6B_CFG_BRLE] = bus_release_enable_r;
                rd_data_nxt[P6B_CFG_WAIT] = wait_pin_enable_r;
                rd_data_nxt[P6B_CFG_MODE] = expanded_mode_in;
            end
            default: begin
                rd_data_nxt = 8'h00;
            end
        endcase
    end

    // single-wait answer: ack one cycle after the strobe, dropped the next cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            wb_ack_out <= ack_nxt;
            if (ack_nxt && !wb_we_in) begin
                wb_dat_out <= {24'h000000, rd_data_nxt};
            end
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_ddr_bit7;
        port_six_direction_ctl_r[7] && port_six_output_data_r[7];
    endproperty
    a_ddr_bit7: assert property (p_ddr_bit7) else $error("reserved bit 7 lost");

    property p_clk_pin;
        !clock_out_stop_r |=> pin_oe_out[7] && pin_out[7] == $past(sys_clock_level_in);
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("pin 7 not clock");

    property p_strobes;
        expanded_mode_in |=> pin_oe_out[6:3] == 4'hF
            && pin_out[3] == $past(address_strobe_n_in);
    endproperty
    a_strobes: assert property (p_strobes) else $error("strobe pins wrong");

    property p_back;
        expanded_mode_in && bus_release_enable_r |=> pin_oe_out[2] && !pin_oe_out[1];
    endproperty
    a_back: assert property (p_back) else $error("bus release pins wrong");

    property p_exp_port;
        expanded_mode_in && !bus_release_enable_r
            |=> pin_oe_out[2:1] == $past(port_six_direction_ctl_r[2:1]);
    endproperty
    a_exp_port: assert property (p_exp_port) else $error("port pin dir wrong");

    property p_single;
        !expanded_mode_in |=> pin_oe_out[6:0] == $past(port_six_direction_ctl_r[6:0])
            && pin_out[6:0] == $past(port_six_output_data_r[6:0]);
    endproperty
    a_single: assert property (p_single) else $error("single-chip pin wrong");

    property p_ddr_read;
        ack_nxt && !wb_we_in && sel == P6B_SEL_DDR |=> wb_ack_out && wb_dat_out == 32'hFF;
    endproperty
    a_ddr_read: assert property (p_ddr_read) else $error("direction read not ones");

    property p_hw_stby;
        hw_standby_in |=> port_six_direction_ctl_r == P6B_DDR_RST
            && port_six_output_data_r == P6B_DR_RST;
    endproperty
    a_hw_stby: assert property (p_hw_stby) else $error("standby reset missed");

    property p_dr_read;
        ack_nxt && !wb_we_in && sel == P6B_SEL_DR && !clock_out_stop_r
            |=> wb_dat_out[7] && wb_dat_out[0] == $past(port_six_direction_ctl_r[0] ?
                port_six_output_data_r[0] : pin_level[0]);
    endproperty
    a_dr_read: assert property (p_dr_read) else $error("data read wrong");

    property p_wait;
        expanded_mode_in && wait_pin_enable_r |=> !pin_oe_out[0];
    endproperty
    a_wait: assert property (p_wait) else $error("wait pin driven");

    property p_ack_once;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");

    c_ddr_write: cover property (wr_en && sel == P6B_SEL_DDR);
    c_dr_read:   cover property (ack_nxt && !wb_we_in && sel == P6B_SEL_DR);
    c_wait_on:   cover property (expanded_mode_in && wait_pin_enable_r);
    c_stby:      cover property (sw_standby_in && pin_oe_out[0]);
endmodule : p6b_port

// file: tb/p6b_pins_model.sv
`timescale 1ns/1ns
module p6b_pins_model (
    // design drive
    input  wire logic [7:0] pin_out_in,
    input  wire logic [7:0] pin_oe_in,
    // far-side device levels
    input  wire logic [7:0] ext_in,
    output logic      [7:0] level_out
);
    // an undriven pin shows the outside level, pin 0 carrying the wait input
    assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_in);
endmodule : p6b_pins_model

// file: tb/p6b_port_tb.sv
`timescale 1ns/1ns
module p6b_port_tb;
    import p6b_pkg::*;
    localparam logic [21:0] A_DDR = {P6B_IDX_DDR, 2'h0};
    localparam logic [21:0] A_DR  = {P6B_IDX_DR, 2'h0};
    localparam logic [21:0] A_CFG = {P6B_IDX_CFG, 2'h0};
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [21:0] adr = '0;
    logic [31:0] wdat = '0, rdat, rd;
    logic        ack, exm = 0, hws = 0, sws = 0, sclk = 0, back = 1, brq, wrq, swseen;
    logic [3:0]  stbs = 4'hF;
    logic [7:0]  pout, poe, plvl, ext = 8'h00, dd, dv, eo;
    logic [2:0]  cf;
    int          seed = 35, bad_count = 0, checked = 0;

    always #20 clk = ~clk;
    always @(posedge clk) sclk <= ~sclk;

    p6b_port dut_u (.mclk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .expanded_mode_in(exm),
        .hw_standby_in(hws), .sw_standby_in(sws), .sys_clock_level_in(sclk),
        .low_byte_write_strobe_n_in(stbs[3]), .high_byte_write_strobe_n_in(stbs[2]),
        .read_strobe_n_in(stbs[1]), .address_strobe_n_in(stbs[0]),
        .bus_release_ack_n_in(back), .bus_release_request_n_out(brq),
        .wait_request_n_out(wrq), .sw_standby_seen_out(swseen), .pin_in(plvl),
        .pin_out(pout), .pin_oe_out(poe));
    p6b_pins_model pins_u (.pin_out_in(pout), .pin_oe_in(poe), .ext_in(ext),
        .level_out(plvl));

    function automatic logic [7:0] exp_oe(logic ex, logic [2:0] c, logic [7:0] d);
        logic [7:0] o;
        o = {~c[0], d[6:0]};
        if (ex) begin
            o[6:3] = 4'hF;
            if (c[1]) o[2:1] = 2'b10;
            if (c[2]) o[0] = 1'b0;
        end
        return o;
    endfunction : exp_oe

    function automatic logic [7:0] exp_dr(logic [2:0] c, logic [7:0] d, logic [7:0] v,
                                          logic [7:0] e);
        return {c[0] ? e[7] : 1'b1, (d[6:0] & v[6:0]) | (~d[6:0] & e[6:0])};
    endfunction : exp_dr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    // waits for ack however long it takes; only the watchdog ends a hang
    task automatic wb(input logic w, input logic [21:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk);
    endtask : wb

    // synchroniser plus output register need a few cycles after any change
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic results();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    initial begin
        #(40 * 20000);
        bad_count++;
        results();
    end

    initial begin
        ext <= 8'($random(seed));
        repeat (5) @(posedge clk);
        rst_n <= 1;
        settle();
        chk(poe, 8'h80);
        chk(pout[7], !sclk);
        wb(0, A_DDR, 0);
        chk(rd, 32'hFF);
        wb(0, A_DR, 0);
        chk(rd, {24'h0, exp_dr(3'h0, 8'h80, 8'h80, ext)});
        for (int i = 0; i < 12; i++) begin
            dd = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : 8'($random(seed));
            dv = 8'($random(seed));
            ext <= 8'($random(seed));
            wb(1, A_DDR, dd);
            wb(1, A_DR, dv);
            settle();
            chk(poe, exp_oe(0, 3'h0, dd));
            chk(pout[6:0] & dd[6:0], dv[6:0] & dd[6:0]);
            wb(0, A_DR, 0);
            chk(rd, {24'h0, exp_dr(3'h0, dd, dv, ext)});
            wb(0, A_DDR, 0);
            chk(rd, 32'hFF);
        end
        wb(1, A_CFG, 8'h01);
        dv = 8'h00;
        wb(1, A_DR, dv);
        settle();
        chk(poe[7], 1'b0);
        wb(0, A_DR, 0);
        chk(rd, {24'h0, exp_dr(3'h1, dd, dv, ext)});
        wb(1, A_CFG, 8'h00);
        sws <= 1;
        settle();
        chk(poe, exp_oe(0, 3'h0, dd));
        chk(pout[6:0] & dd[6:0], dv[6:0] & dd[6:0]);
        chk(swseen, 1'b1);
        wb(0, A_DR, 0);
        chk(rd, {24'h0, exp_dr(3'h0, dd, dv, ext)});
        sws <= 0;
        hws <= 1;
        repeat (2) @(posedge clk);
        hws <= 0;
        settle();
        chk(poe, 8'h80);
        wb(0, A_DR, 0);
        chk(rd, {24'h0, exp_dr(3'h0, 8'h80, 8'h80, ext)});
        wb(0, 22'h000100, 0);
        chk(rd, 32'h0);
        exm <= 1;
        for (int c = 0; c < 8; c++) begin
            cf = c[2:0];
            dd = 8'($random(seed));
            if (cf[2]) dd[0] = 1'b0;
            stbs <= 4'($random(seed));
            back <= 1'($random(seed));
            ext <= 8'($random(seed));
            wb(1, A_DDR, dd);
            wb(1, A_CFG, {5'h0, cf});
            settle();
            chk(poe, exp_oe(1, cf, dd));
            chk(pout[6:3], stbs);
            if (cf[1]) chk(pout[2], back);
            chk(brq, cf[1] ? ext[1] : 1'b1);
            chk(wrq, cf[2] ? ext[0] : 1'b1);
        end
        results();
    end
endmodule : p6b_port_tb
